/* rtl/fsv_core.sv */
// Special-value, flush-to-zero and exception handling of the FP datapath.
//
// Overview of operation
// - Handles single, double and 32-bit unsigned/signed integers; no extended.
// - All-ones exponent with nonzero fraction is NaN; top fraction bit 0 signals.
// - Default NaN: sign 0, exponent all ones, only top fraction bit set.
// - Signaling NaN raises invalid; unhandled, the result is default quiet NaN.
// - Outside fast mode, arithmetic with NaN operands bounces to support code.
// - Transfers move NaNs unchanged, with no invalid flag and no bounce.
// - Copy, abs and negate pass NaNs, changing sign only, no flags.
// - Fast mode: arithmetic NaN gives default NaN; signaling NaN sets invalid.
// - Compare writes condition codes; a move copies them to host status.
// - Plain compare: signaling NaN unordered and invalid, traps if enabled.
// - Signaling compare: any NaN operand raises invalid, result unordered.
// - Underflow uses tininess after rounding and subnormalization loss.
// - Flush mode: result tiny before rounding becomes +0, sets underflow.
// - No flush: tiny risk bounces; otherwise result returned, inexact possible.
// - Exceptions are imprecise, taken when the next instruction is issued.
// - On exception entry sources are kept and the destination is not written.
// - Flush mode makes subnormal arithmetic inputs +0; abs/compare/negate not.
// - Input flush sets input-subnormal flag; result flush sets underflow flag.
// - Default-NaN enable is control bit 25, reset to 0.
// - Default-NaN mode alone still bounces NaN arithmetic; only fast mode returns default NaN.
// - Transfers, copy, abs, negate keep NaN fractions and set no flags.
// - Fast mode means flush on, default-NaN on and all traps disabled.
// - Exception flags are sticky until software rewrites the control register.
`timescale 1ns/1ps
`default_nettype none
`include "fsv_defs.svh"
module fsv_core
    import fsv_pkg::*;
(
    input  wire logic        sys_clk,          // System clock, 100 MHz
    input  wire logic        srst,             // Synchronous reset
    input  wire logic        issue_valid,      // Instruction offered
    output logic             issue_ready,      // Instruction can be taken
    input  wire fsv_req_t    issue_req,        // Instruction and operands
    input  wire logic        ctrl_wr_en,       // Control register write
    input  wire logic [31:0] ctrl_wr_data,     // Control register value
    output logic [31:0]      fp_status_control_reg, // Control/status
    output logic             arith_start,      // Start the arithmetic unit
    output logic [63:0]      arith_opa,        // Flushed first operand
    output logic [63:0]      arith_opb,        // Flushed second operand
    input  wire logic        arith_done,       // Arithmetic result ready
    input  wire logic [63:0] arith_res,        // Rounded result
    input  wire logic        arith_tiny_pre,   // Tiny before rounding
    input  wire logic        arith_tiny_risk,  // Tininess could occur
    input  wire logic        arith_tiny_post,  // Tiny after rounding
    input  wire logic        arith_inexact,    // Result was rounded
    output logic             res_valid,        // Destination write pulse
    output logic [63:0]      res_data,         // Destination value
    output logic             exc_pending,      // Exceptional state held
    output logic             exc_entry,        // Support code entry pulse
    output logic             host_flags_valid, // Host flag copy pulse
    output logic [3:0]       host_status_flags // Codes for host status
);
    fsv_state_t  state_q, state_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic        start_q, start_d;
    logic [63:0] opa_q, opa_d, opb_q, opb_d;
    logic        wait_dbl_q, wait_dbl_d;
    logic        res_valid_q, res_valid_d;
    logic [63:0] res_q, res_d;
    logic        pend_q, pend_d;
    logic        entry_q, entry_d;
    logic        hvalid_q, hvalid_d;
    logic [3:0]  hflags_q, hflags_d;
    logic [31:0] flag_set;
    logic        cc_we;
    fsv_class_t  cls_a, cls_b;
    logic [3:0]  cmp_cc;

    wire take = issue_valid & issue_ready;
    wire fsv_op_t op = issue_req.op;
    wire dbl = issue_req.fmt == FSV_FMT_D;
    // Integer formats are never classified as special values.
    wire is_fp = (issue_req.fmt == FSV_FMT_S) | dbl;
    wire uses_b = (op == FSV_OP_CMP) | (op == FSV_OP_CMPE)
                | (op == FSV_OP_ARITH);
    wire any_nan = cls_a.nan | (uses_b & cls_b.nan);
    wire any_snan = cls_a.snan | (uses_b & cls_b.snan);
    wire fz = ctrl_q[`FSV_FZ_BIT];
    wire dn = ctrl_q[`FSV_DN_BIT];
    wire invalid_op_trap_enable = ctrl_q[`FSV_IOE_BIT];
    wire fast_mode = fz & dn & ~|(ctrl_q & `FSV_TRAP_EN_MASK);
    wire [63:0] sign_mask = dbl ? `FSV_D_SIGN_MASK : `FSV_S_SIGN_MASK;
    wire [63:0] dflt_nan = dbl ? `FSV_D_DNAN : `FSV_S_DNAN;
    wire [63:0] abs_res = issue_req.opa & ~sign_mask;
    wire [63:0] neg_res = issue_req.opa ^ sign_mask;
    wire cmp_inv = (op == FSV_OP_CMP) ? any_snan : any_nan;
    wire cmp_trap = cmp_inv & invalid_op_trap_enable;
    wire nan_bounce = any_nan & ~fast_mode;
    wire flush_a = fz & cls_a.sub;
    wire flush_b = fz & cls_b.sub;
    wire uf_bounce = ~fz & (arith_tiny_risk | arith_tiny_post);
    wire [63:0] arith_word = wait_dbl_q ? arith_res
                           : {32'h0, arith_res[`FSV_S_WORD_MSB:0]};

    fsv_classify u_cls_a (
        .value  (issue_req.opa),
        .is_dbl (dbl),
        .is_fp  (is_fp),
        .cls    (cls_a)
    );
    fsv_classify u_cls_b (
        .value  (issue_req.opb),
        .is_dbl (dbl),
        .is_fp  (is_fp),
        .cls    (cls_b)
    );
    fsv_compare u_cmp (
        .a      (issue_req.opa),
        .b      (issue_req.opb),
        .is_dbl (dbl),
        .unord  (any_nan),
        .cc     (cmp_cc)
    );

    always_comb
    begin
        state_d    = state_q;
        start_d    = 1'b0;
        opa_d      = opa_q;
        opb_d      = opb_q;
        wait_dbl_d = wait_dbl_q;
        res_valid_d = 1'b0;
        res_d      = res_q;
        pend_d     = pend_q;
        entry_d    = 1'b0;
        hvalid_d   = 1'b0;
        hflags_d   = hflags_q;
        flag_set   = 32'h0;
        cc_we      = 1'b0;
        if (take && pend_q)
        begin
            // Nothing is written so the support code sees sources intact.
            entry_d = 1'b1;
            pend_d  = 1'b0;
        end
        else if (take)
        begin
            case (op)
                FSV_OP_MOVE:
                begin
                    res_valid_d = 1'b1;
                    res_d       = issue_req.opa;
                end
                FSV_OP_COPY, FSV_OP_ABS, FSV_OP_NEG:
                begin
                    res_valid_d = 1'b1;
                    res_d = (op == FSV_OP_ABS) ? abs_res
                          : (op == FSV_OP_NEG) ? neg_res
                          : issue_req.opa;
                end
                FSV_OP_CMP, FSV_OP_CMPE:
                begin
                    if (cmp_trap)
                        pend_d = 1'b1;
                    else
                    begin
                        cc_we = 1'b1;
                        flag_set[`FSV_IOC_BIT] = cmp_inv;
                    end
                end
                FSV_OP_MFLAGS:
                begin
                    hvalid_d = 1'b1;
                    hflags_d = ctrl_q[`FSV_CC_MSB:`FSV_CC_LSB];
                end
                FSV_OP_ARITH:
                begin
                    if (nan_bounce)
                        pend_d = 1'b1;
                    else if (any_nan)
                    begin
                        res_valid_d = 1'b1;
                        res_d       = dflt_nan;
                        flag_set[`FSV_IOC_BIT] = any_snan;
                    end
                    else
                    begin
                        start_d    = 1'b1;
                        state_d    = FSV_ST_WAIT;
                        wait_dbl_d = dbl;
                        opa_d = flush_a ? `FSV_POS_ZERO : issue_req.opa;
                        opb_d = flush_b ? `FSV_POS_ZERO : issue_req.opb;
                        flag_set[`FSV_IDC_BIT] = flush_a | flush_b;
                    end
                end
                default:
                begin
                    res_valid_d = 1'b0;
                end
            endcase
        end
        if (state_q == FSV_ST_WAIT && arith_done)
        begin
            state_d = FSV_ST_IDLE;
            if (fz && arith_tiny_pre)
            begin
                res_valid_d = 1'b1;
                res_d       = `FSV_POS_ZERO;
                flag_set[`FSV_UFC_BIT] = 1'b1;
            end
            else if (uf_bounce)
                pend_d = 1'b1;
            else
            begin
                res_valid_d = 1'b1;
                res_d       = arith_word;
                flag_set[`FSV_IXC_BIT] = arith_inexact;
            end
        end
    end

    // A hardware flag event in the same cycle as a software write survives.
    always_comb
    begin
        ctrl_d = ctrl_wr_en ? ctrl_wr_data : ctrl_q;
        if (cc_we)
            ctrl_d[`FSV_CC_MSB:`FSV_CC_LSB] = cmp_cc;
        ctrl_d = ctrl_d | flag_set;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_q <= FSV_ST_IDLE;
            ctrl_q  <= `FSV_CTRL_RESET;
            pend_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ctrl_q  <= ctrl_d;
            pend_q  <= pend_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            start_q     <= 1'b0;
            res_valid_q <= 1'b0;
            entry_q     <= 1'b0;
            hvalid_q    <= 1'b0;
        end
        else
        begin
            start_q     <= start_d;
            res_valid_q <= res_valid_d;
            entry_q     <= entry_d;
            hvalid_q    <= hvalid_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            opa_q      <= `FSV_POS_ZERO;
            opb_q      <= `FSV_POS_ZERO;
            wait_dbl_q <= 1'b0;
            res_q      <= `FSV_POS_ZERO;
            hflags_q   <= 4'h0;
        end
        else
        begin
            opa_q      <= opa_d;
            opb_q      <= opb_d;
            wait_dbl_q <= wait_dbl_d;
            res_q      <= res_d;
            hflags_q   <= hflags_d;
        end
    end

    assign issue_ready           = state_q == FSV_ST_IDLE;
    assign fp_status_control_reg = ctrl_q;
    assign arith_start           = start_q;
    assign arith_opa             = opa_q;
    assign arith_opb             = opb_q;
    assign res_valid             = res_valid_q;
    assign res_data              = res_q;
    assign exc_pending           = pend_q;
    assign exc_entry             = entry_q;
    assign host_flags_valid      = hvalid_q;
    assign host_status_flags     = hflags_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    wire plain = take & ~pend_q;
    fast_nan_a: assert property (plain && op == FSV_OP_ARITH && any_nan
        && fast_mode |=> res_valid && res_data == $past(dflt_nan)
        && fp_status_control_reg[`FSV_IOC_BIT] == ($past(any_snan)
        | $past(ctrl_wr_en ? ctrl_wr_data[`FSV_IOC_BIT]
                           : ctrl_q[`FSV_IOC_BIT])))
        else $error("fast mode NaN result wrong");
    nan_bounce_a: assert property (plain && op == FSV_OP_ARITH && any_nan
        && !fast_mode |=> exc_pending && !res_valid && !arith_start)
        else $error("NaN arithmetic not bounced");
    exc_entry_a: assert property (take && pend_q |=> exc_entry
        && !res_valid && !exc_pending && !arith_start)
        else $error("exception entry wrong");
    move_keep_a: assert property (plain && op == FSV_OP_MOVE && !ctrl_wr_en
        |=> res_valid && res_data == $past(issue_req.opa)
        && $stable(fp_status_control_reg))
        else $error("transfer altered value or flags");
    cmp_unord_a: assert property (plain && op == FSV_OP_CMP && any_nan
        && !cmp_trap |=> fp_status_control_reg[`FSV_CC_MSB:`FSV_CC_LSB]
        == `FSV_CC_UN)
        else $error("NaN compare not unordered");
    cmpe_inv_a: assert property (plain && op == FSV_OP_CMPE && any_nan
        && !invalid_op_trap_enable |=> fp_status_control_reg[`FSV_IOC_BIT])
        else $error("signaling compare missed invalid");
    ftz_result_a: assert property (state_q == FSV_ST_WAIT && arith_done
        && fz && arith_tiny_pre |=> res_valid && res_data == `FSV_POS_ZERO
        && fp_status_control_reg[`FSV_UFC_BIT])
        else $error("tiny result not flushed");
    ufc_sticky_a: assert property (fp_status_control_reg[`FSV_UFC_BIT]
        && !ctrl_wr_en |=> fp_status_control_reg[`FSV_UFC_BIT])
        else $error("underflow flag lost");
    in_flush_a: assert property (plain && op == FSV_OP_ARITH && !any_nan
        && flush_a |=> arith_start && arith_opa == `FSV_POS_ZERO
        && fp_status_control_reg[`FSV_IDC_BIT])
        else $error("subnormal input not flushed");
    dn_reset_a: assert property (disable iff (1'b0)
        srst |=> !fp_status_control_reg[`FSV_DN_BIT])
        else $error("default NaN enable not cleared");
endmodule : fsv_core
`default_nettype wire

/* pkg/fsv_defs.svh */
// Constants of the floating-point special-value handling block.
`ifndef FSV_DEFS_SVH
`define FSV_DEFS_SVH
`define FSV_CC_MSB        31
`define FSV_CC_LSB        28
`define FSV_DN_BIT        25
`define FSV_FZ_BIT        24
`define FSV_IDC_BIT       15
`define FSV_TRAP_EN_MASK  32'h00001f00
`define FSV_IOE_BIT       8
`define FSV_IXC_BIT       4
`define FSV_UFC_BIT       3
`define FSV_IOC_BIT       0
`define FSV_CTRL_RESET    32'h00000000
`define FSV_CC_LT         4'h8
`define FSV_CC_EQ         4'h6
`define FSV_CC_GT         4'h2
`define FSV_CC_UN         4'h3
`define FSV_D_SIGN        63
`define FSV_D_EXP_MSB     62
`define FSV_D_EXP_LSB     52
`define FSV_D_FRAC_MSB    51
`define FSV_S_SIGN        31
`define FSV_S_EXP_MSB     30
`define FSV_S_EXP_LSB     23
`define FSV_S_FRAC_MSB    22
`define FSV_S_WORD_MSB    31
`define FSV_D_SIGN_MASK   64'h8000000000000000
`define FSV_S_SIGN_MASK   64'h0000000080000000
`define FSV_D_DNAN        64'h7ff8000000000000
`define FSV_S_DNAN        64'h000000007fc00000
`define FSV_POS_ZERO      64'h0000000000000000
`endif

/* pkg/fsv_pkg.sv */
// Types of the floating-point special-value handling block.
package fsv_pkg;
    typedef enum logic [7:0] {
        FSV_OP_MOVE   = 8'h01,
        FSV_OP_COPY   = 8'h02,
        FSV_OP_ABS    = 8'h04,
        FSV_OP_NEG    = 8'h08,
        FSV_OP_CMP    = 8'h10,
        FSV_OP_CMPE   = 8'h20,
        FSV_OP_ARITH  = 8'h40,
        FSV_OP_MFLAGS = 8'h80
    } fsv_op_t;
    typedef enum logic [1:0] {
        FSV_FMT_S   = 2'h0,
        FSV_FMT_D   = 2'h1,
        FSV_FMT_U32 = 2'h2,
        FSV_FMT_I32 = 2'h3
    } fsv_fmt_t;
    typedef enum logic [1:0] {
        FSV_ST_IDLE = 2'h1,
        FSV_ST_WAIT = 2'h2
    } fsv_state_t;
    typedef struct packed {
        fsv_op_t     op;
        fsv_fmt_t    fmt;
        logic [63:0] opa;
        logic [63:0] opb;
    } fsv_req_t;
    typedef struct packed {
        logic nan;
        logic snan;
        logic sub;
        logic zero;
    } fsv_class_t;
endpackage : fsv_pkg

/* rtl/fsv_classify.sv */
// Operand classifier: NaN, signaling NaN, subnormal and zero.
`timescale 1ns/1ps
`default_nettype none
`include "fsv_defs.svh"
module fsv_classify
    import fsv_pkg::*;
(
    input  wire logic [63:0] value,    // Operand bits, single in low word
    input  wire logic        is_dbl,   // Operand is double precision
    input  wire logic        is_fp,    // Operand is a floating-point value
    output fsv_class_t       cls       // Classification result
);
    wire exp_ones = is_dbl ? &value[`FSV_D_EXP_MSB:`FSV_D_EXP_LSB]
                           : &value[`FSV_S_EXP_MSB:`FSV_S_EXP_LSB];
    wire exp_zero = is_dbl ? ~|value[`FSV_D_EXP_MSB:`FSV_D_EXP_LSB]
                           : ~|value[`FSV_S_EXP_MSB:`FSV_S_EXP_LSB];
    wire frac_nz  = is_dbl ? |value[`FSV_D_FRAC_MSB:0]
                           : |value[`FSV_S_FRAC_MSB:0];
    wire frac_top = is_dbl ? value[`FSV_D_FRAC_MSB]
                           : value[`FSV_S_FRAC_MSB];
    assign cls.nan  = is_fp & exp_ones & frac_nz;
    assign cls.snan = is_fp & exp_ones & frac_nz & ~frac_top;
    assign cls.sub  = is_fp & exp_zero & frac_nz;
    assign cls.zero = is_fp & exp_zero & ~frac_nz;
endmodule : fsv_classify
`default_nettype wire

/* rtl/fsv_compare.sv */
// Ordered/unordered comparator producing condition codes.
`timescale 1ns/1ps
`default_nettype none
`include "fsv_defs.svh"
module fsv_compare
    import fsv_pkg::*;
(
    input  wire logic [63:0] a,        // First operand
    input  wire logic [63:0] b,        // Second operand
    input  wire logic        is_dbl,   // Operands are double precision
    input  wire logic        unord,    // Either operand is a NaN
    output logic [3:0]       cc        // Condition code result
);
    wire        sa = is_dbl ? a[`FSV_D_SIGN] : a[`FSV_S_SIGN];
    wire        sb = is_dbl ? b[`FSV_D_SIGN] : b[`FSV_S_SIGN];
    wire [62:0] ma = is_dbl ? a[`FSV_D_EXP_MSB:0]
                            : {32'h0, a[`FSV_S_EXP_MSB:0]};
    wire [62:0] mb = is_dbl ? b[`FSV_D_EXP_MSB:0]
                            : {32'h0, b[`FSV_S_EXP_MSB:0]};
    // Plus and minus zero are equal although their bits differ.
    wire both_zero = ~|ma & ~|mb;
    wire same = (sa == sb) & (ma == mb);
    wire eq = both_zero | same;
    wire lt = ~eq & ((sa & ~sb) | (~sa & ~sb & (ma < mb))
                     | (sa & sb & (ma > mb)));
    assign cc = unord ? `FSV_CC_UN : eq ? `FSV_CC_EQ
              : lt ? `FSV_CC_LT : `FSV_CC_GT;
endmodule : fsv_compare
`default_nettype wire

/* testbench/fsv_arith_model.sv */
// Behavioural arithmetic unit that answers the core after a set latency.
`timescale 1ns/1ps
`default_nettype none
module fsv_arith_model
(
    input  wire logic        sys_clk,         // Clock
    input  wire logic        srst,            // Synchronous reset
    input  wire logic        arith_start,     // Operation start
    input  wire logic [63:0] arith_opa,       // First operand
    input  wire logic [3:0]  cfg_lat,         // Answer latency, at least 1
    input  wire logic        cfg_pre,         // Report tiny before rounding
    input  wire logic        cfg_risk,        // Report tininess risk
    input  wire logic        cfg_inx,         // Report inexact
    output logic             arith_done,      // Result pulse
    output logic [63:0]      arith_res,       // Result
    output logic             arith_tiny_pre,  // Tiny before rounding
    output logic             arith_tiny_risk, // Tininess risk
    output logic             arith_tiny_post, // Tiny after rounding
    output logic             arith_inexact    // Inexact
);
    logic [3:0]  cnt_q;
    logic [63:0] res_q;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            cnt_q <= 4'h0;
        else if (arith_start)
            cnt_q <= cfg_lat;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
        if (arith_start)
            res_q <= arith_opa + 64'h1;
    end

    // Outside the done pulse every answer line shows a wrong value.
    assign arith_done      = (cnt_q == 4'h1);
    assign arith_res       = arith_done ? res_q : ~res_q;
    assign arith_tiny_pre  = arith_done ? cfg_pre : ~cfg_pre;
    assign arith_tiny_risk = arith_done ? cfg_risk : ~cfg_risk;
    assign arith_tiny_post = arith_done ? cfg_risk : ~cfg_risk;
    assign arith_inexact   = arith_done ? cfg_inx : ~cfg_inx;
endmodule : fsv_arith_model
`default_nettype wire

/* testbench/fsv_core_bench.sv */
// Self-checking bench of the special-value handling core.
`timescale 1ns/1ps
`default_nettype none
`include "fsv_defs.svh"
module fsv_core_bench;
    import fsv_pkg::*;
    localparam logic [31:0] FAST   = 32'h03000000;
    localparam logic [63:0] S_ONE  = 64'h3f800000;
    localparam logic [63:0] S_TWO  = 64'h40000000;
    localparam logic [63:0] S_SNAN = 64'h7f800001;
    localparam logic [63:0] S_QNAN = 64'h7fc00005;
    logic        sys_clk, srst, issue_valid, issue_ready, ctrl_wr_en, rdy_c1;
    logic        arith_start, arith_done, arith_tiny_pre, arith_tiny_risk;
    logic        arith_tiny_post, arith_inexact, res_valid, exc_pending;
    logic        exc_entry, host_flags_valid, cfg_pre, cfg_risk, cfg_inx;
    logic [63:0] arith_opa, arith_opb, arith_res, res_data;
    logic [31:0] ctrl_wr_data, fp_status_control_reg;
    logic [3:0]  host_status_flags, cfg_lat;
    fsv_req_t    issue_req;
    int          errors, cmp_count;

    fsv_core i_dut (.sys_clk, .srst, .issue_valid, .issue_ready, .issue_req,
        .ctrl_wr_en, .ctrl_wr_data, .fp_status_control_reg, .arith_start,
        .arith_opa, .arith_opb, .arith_done, .arith_res, .arith_tiny_pre,
        .arith_tiny_risk, .arith_tiny_post, .arith_inexact, .res_valid,
        .res_data, .exc_pending, .exc_entry, .host_flags_valid,
        .host_status_flags);
    fsv_arith_model i_arith (.sys_clk, .srst, .arith_start, .arith_opa,
        .cfg_lat, .cfg_pre, .cfg_risk, .cfg_inx, .arith_done, .arith_res,
        .arith_tiny_pre, .arith_tiny_risk, .arith_tiny_post, .arith_inexact);

    always #5 sys_clk = ~sys_clk;

    task automatic results();
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] d);
        @(negedge sys_clk);
        ctrl_wr_en = 1'b1;
        ctrl_wr_data = d;
        @(negedge sys_clk);
        ctrl_wr_en = 1'b0;
    endtask : wr

    // Returns in the first cycle of the answer.
    task automatic issue(input fsv_op_t op, input fsv_fmt_t fm,
                         input logic [63:0] a, input logic [63:0] b);
        int n;
        n = 0;
        @(negedge sys_clk);
        issue_valid = 1'b1;
        issue_req = '{op, fm, a, b};
        while (issue_ready !== 1'b1 && n < 50)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        issue_valid = 1'b0;
        rdy_c1 = issue_ready;
        while (op == FSV_OP_ARITH && res_valid !== 1'b1
               && exc_pending !== 1'b1 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        // Waits that add up to 50 cycles or more, for ready or for the answer, are a hang.
        if (n >= 50)
        begin
            errors++;
            $display("Error at %0t: waited %h limit %h", $time, n, 50);
        end
    endtask : issue

    task automatic clear_exc();
        issue(FSV_OP_MOVE, FSV_FMT_S, S_ONE, S_ONE);
        chk({exc_entry, res_valid, exc_pending}, 3'b100);
    endtask : clear_exc

    task automatic t_pass();
        fsv_op_t     ops [4] = '{FSV_OP_MOVE, FSV_OP_COPY, FSV_OP_ABS,
                                 FSV_OP_NEG};
        logic [63:0] a = 64'hff800001;
        wr(FAST);
        for (int i = 0; i < 4; i++)
        begin
            issue(ops[i], FSV_FMT_S, a, S_ONE);
            chk({res_valid, exc_pending}, 2'b10);
            chk(res_data, i < 2 ? a : 64'h7f800001);
        end
        chk(fp_status_control_reg, FAST);
    endtask : t_pass

    task automatic t_cmp();
        logic [63:0] ta [6] = '{S_ONE, S_TWO, 64'h0, S_QNAN, S_SNAN, S_ONE};
        logic [63:0] tb [6] = '{S_TWO, S_ONE, 64'h80000000, S_ONE, S_ONE,
                                S_ONE};
        logic [4:0]  ex [6] = '{5'h10, 5'h04, 5'h0c, 5'h06, 5'h07, 5'h0d};
        wr(32'h0);
        for (int i = 0; i < 6; i++)
        begin
            issue(FSV_OP_CMP, FSV_FMT_S, ta[i], tb[i]);
            chk({fp_status_control_reg[31:28], fp_status_control_reg[0]},
                ex[i]);
        end
        issue(FSV_OP_MFLAGS, FSV_FMT_S, S_ONE, S_ONE);
        chk({host_flags_valid, host_status_flags}, 5'h16);
        wr(32'h0);
        issue(FSV_OP_CMPE, FSV_FMT_D, 64'h3ff0000000000000,
              64'h7ff8000000000001);
        chk({fp_status_control_reg[31:28], fp_status_control_reg[0]},
            5'h07);
    endtask : t_cmp

    task automatic t_trap();
        wr(32'h00000100);
        issue(FSV_OP_CMP, FSV_FMT_D, 64'h7ff0000000000001, 64'h0);
        chk(exc_pending, 1'b1);
        chk(fp_status_control_reg, 32'h00000100);
        clear_exc();
    endtask : t_trap

    task automatic t_bounce();
        logic [31:0] md [3] = '{32'h0, 32'h02000000, FAST | 32'h00001000};
        for (int i = 0; i < 3; i++)
        begin
            wr(md[i]);
            issue(FSV_OP_ARITH, FSV_FMT_D, 64'h7ff8000000000003, 64'h0);
            chk({exc_pending, res_valid}, 2'b10);
            clear_exc();
        end
    endtask : t_bounce

    task automatic t_fast();
        wr(FAST);
        issue(FSV_OP_ARITH, FSV_FMT_D, 64'h7ff8000000000007, 64'h0);
        chk(res_data, `FSV_D_DNAN);
        chk(fp_status_control_reg[0], 1'b0);
        issue(FSV_OP_ARITH, FSV_FMT_S, S_ONE, S_SNAN);
        chk(res_data, `FSV_S_DNAN);
        chk(fp_status_control_reg[0], 1'b1);
    endtask : t_fast

    task automatic t_flush();
        wr(FAST);
        cfg_pre = 1'b1;
        issue(FSV_OP_ARITH, FSV_FMT_S, 64'h1, S_ONE);
        chk(arith_opa, 64'h0);
        chk(arith_opb, S_ONE);
        chk(res_data, `FSV_POS_ZERO);
        chk(fp_status_control_reg[15:0], 16'h8008);
        cfg_pre = 1'b0;
        issue(FSV_OP_ABS, FSV_FMT_S, 64'h80000001, S_ONE);
        chk(res_data, 64'h1);
        chk(fp_status_control_reg[15:0], 16'h8008);
        wr(FAST);
        chk(fp_status_control_reg, FAST);
    endtask : t_flush

    task automatic t_under();
        wr(32'h0);
        cfg_risk = 1'b1;
        cfg_lat = 4'h5;
        issue(FSV_OP_ARITH, FSV_FMT_S, S_TWO, S_ONE);
        chk(rdy_c1, 1'b0);
        chk({exc_pending, res_valid}, 2'b10);
        clear_exc();
        cfg_risk = 1'b0;
        cfg_inx = 1'b1;
        cfg_lat = 4'h1;
        issue(FSV_OP_ARITH, FSV_FMT_S, S_TWO, S_ONE);
        chk(res_data, S_TWO + 64'h1);
        chk(fp_status_control_reg[4:3], 2'b10);
    endtask : t_under

    initial
    begin
        sys_clk = 1'b0;
        srst = 1'b1;
        issue_valid = 1'b0;
        issue_req = '0;
        ctrl_wr_en = 1'b0;
        ctrl_wr_data = 32'h0;
        cfg_lat = 4'h1;
        cfg_pre = 1'b0;
        cfg_risk = 1'b0;
        cfg_inx = 1'b0;
        errors = 0;
        cmp_count = 0;
        fork
        begin
            #50us;
            errors++;
            results();
        end
        join_none
        repeat (10) @(negedge sys_clk);
        srst = 1'b0;
        chk(fp_status_control_reg, `FSV_CTRL_RESET);
        chk({issue_ready, exc_pending}, 2'b10);
        t_pass();
        t_cmp();
        t_trap();
        t_bounce();
        t_fast();
        t_flush();
        t_under();
        results();
    end
endmodule : fsv_core_bench
`default_nettype wire
